// ===== shared/tuner_cfg_defs.svh
// Offsets, field positions, reset values and timing counts of the config/test group
`ifndef TUNER_CFG_DEFS_SVH
`define TUNER_CFG_DEFS_SVH
`define OFS_SYS_CFG3 4'h6
`define OFS_TEST_ONE 4'h7
`define OFS_TEST_TWO 4'h8
`define OFS_BOOT_CFG 4'h9
`define RST_SYS_CFG3 16'h0000
`define RST_TEST_ONE 16'h0100
`define RST_TEST_TWO 16'h0000
`define RST_BOOT_CFG 16'h0000
`define SYS_CFG3_RSVD_MASK 16'h0e00
`define POS_RATE 14
`define POS_DEPTH 12
`define POS_EXTENDED_VOLUME_RANGE 8
`define POS_SNR 4
`define POS_IMP 0
`define POS_XOSC 15
`define POS_AHIZ 14
`define EXTENDED_VOLUME_RANGE_SHIFT_DB 30
`define DEPTH_BASE_DB 16
`define RATE_FASTEST_NS 1000
`define RATE_STEP_CYC 4
`endif

// ===== shared/tuner_cfg_pkg.sv
// Types shared by the config/test register group
package tuner_cfg_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0] addr_t;
    typedef logic [5:0] atten_t;
endpackage

// ===== rtl/softmute_ramp.sv
// Softmute attenuation ramp stepped at the selected rate
`include "tuner_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module softmute_ramp (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic mute_req_in,
    input wire logic [1:0] rate_in,
    input wire logic [4:0] depth_db_in,
    // Result
    output logic [4:0] atten_db_out
);
    localparam int unsigned BASE_CYC = (`RATE_FASTEST_NS + 9) / 10;
    // Thirteen bits so the slowest rate (64 x base) does not wrap
    logic [12:0] div_q;
    logic [12:0] lim;
    logic step_en;
    always_comb begin
        lim = 13'(BASE_CYC) << (2 * rate_in);
    end
    assign step_en = (div_q >= lim - 13'h0001);
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || step_en) begin
            div_q <= 13'h0000;
        end else begin
            div_q <= div_q + 13'h0001;
        end
    end
    // One dB per step so the audio never jumps
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            atten_db_out <= 5'h00;
        end else if (step_en) begin
            if (mute_req_in && atten_db_out < depth_db_in) begin
                atten_db_out <= atten_db_out + 5'h01;
            end else if (!mute_req_in && atten_db_out != 5'h00) begin
                atten_db_out <= atten_db_out - 5'h01;
            end else if (atten_db_out > depth_db_in) begin
                atten_db_out <= atten_db_out - 5'h01;
            end
        end
    end
endmodule // softmute_ramp
`default_nettype wire

// ===== rtl/tuner_config_test_registers.sv
// Configuration and test register group with audio bias and softmute control
`include "tuner_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tuner_config_test_registers (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire tuner_cfg_pkg::addr_t addr_in,
    input wire tuner_cfg_pkg::word_t wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output tuner_cfg_pkg::word_t rdata_out,
    // Device state
    input wire logic power_enable_in,
    input wire logic vio_present_in,
    input wire logic [3:0] volume_in,
    input wire logic softmute_req_in,
    // Controls out
    output logic [1:0] softmute_rate_out,
    output logic [4:0] softmute_atten_db_out,
    output logic [5:0] volume_atten_db_out,
    output logic volume_mute_out,
    output logic [3:0] seek_snr_threshold_out,
    output logic seek_snr_check_out,
    output logic [3:0] seek_impulse_threshold_out,
    output logic seek_impulse_check_out,
    output logic crystal_osc_enable_out,
    output logic left_audio_out_bias_out,
    output logic right_audio_out_bias_out
);
    import tuner_cfg_pkg::*;
    word_t cfg3_q, test1_q, test2_q, boot_q;
    logic [1:0] pwr_sync_q, vio_sync_q;
    logic [4:0] depth_db;
    logic [4:0] ramp_db;
    logic hiz_d;
    // Pins from outside the clock domain
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pwr_sync_q <= 2'h0;
            vio_sync_q <= 2'h0;
        end else begin
            pwr_sync_q <= {pwr_sync_q[0], power_enable_in};
            vio_sync_q <= {vio_sync_q[0], vio_present_in};
        end
    end
    // Storage; reserved bits are kept as written, the host owns them
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cfg3_q <= `RST_SYS_CFG3;
            test1_q <= `RST_TEST_ONE;
            test2_q <= `RST_TEST_TWO;
            boot_q <= `RST_BOOT_CFG;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_SYS_CFG3: cfg3_q <= wdata_in;
                `OFS_TEST_ONE: test1_q <= wdata_in;
                `OFS_TEST_TWO: test2_q <= wdata_in;
                `OFS_BOOT_CFG: boot_q <= wdata_in;
                default: ;
            endcase
        end
    end
    // Read data for one cycle, zero when unmapped or idle
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || !rd_in) begin
            rdata_out <= 16'h0000;
        end else begin
            case (addr_in)
                `OFS_SYS_CFG3: rdata_out <= cfg3_q;
                `OFS_TEST_ONE: rdata_out <= test1_q;
                `OFS_TEST_TWO: rdata_out <= test2_q;
                `OFS_BOOT_CFG: rdata_out <= boot_q;
                default: rdata_out <= 16'h0000;
            endcase
        end
    end
    // Depth code to dB, two dB per step
    assign depth_db = 5'(`DEPTH_BASE_DB) - {2'h0, cfg3_q[`POS_DEPTH +: 2], 1'b0};
    softmute_ramp u_ramp (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .mute_req_in(softmute_req_in),
        .rate_in(cfg3_q[`POS_RATE +: 2]),
        .depth_db_in(depth_db),
        .atten_db_out(ramp_db)
    );
    // Bias only while powered down with supply present
    assign hiz_d = test1_q[`POS_AHIZ] && !pwr_sync_q[1] && vio_sync_q[1];
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            softmute_rate_out <= 2'h0;
            softmute_atten_db_out <= 5'h00;
            volume_atten_db_out <= 6'h00;
            volume_mute_out <= 1'b1;
            seek_snr_threshold_out <= 4'h0;
            seek_snr_check_out <= 1'b0;
            seek_impulse_threshold_out <= 4'h0;
            seek_impulse_check_out <= 1'b0;
            crystal_osc_enable_out <= 1'b0;
            left_audio_out_bias_out <= 1'b0;
            right_audio_out_bias_out <= 1'b0;
        end else begin
            softmute_rate_out <= cfg3_q[`POS_RATE +: 2];
            softmute_atten_db_out <= ramp_db;
            // Code 15 is 0 dB without extended range (30 dB with it), each step below adds 2 dB
            volume_atten_db_out <= {1'b0, 4'hf - volume_in, 1'b0}
                + (cfg3_q[`POS_EXTENDED_VOLUME_RANGE] ? 6'(`EXTENDED_VOLUME_RANGE_SHIFT_DB) : 6'h00);
            volume_mute_out <= (volume_in == 4'h0);
            seek_snr_threshold_out <= cfg3_q[`POS_SNR +: 4];
            seek_snr_check_out <= (cfg3_q[`POS_SNR +: 4] != 4'h0);
            seek_impulse_threshold_out <= cfg3_q[`POS_IMP +: 4];
            seek_impulse_check_out <= (cfg3_q[`POS_IMP +: 4] != 4'h0);
            crystal_osc_enable_out <= test1_q[`POS_XOSC];
            left_audio_out_bias_out <= hiz_d;
            right_audio_out_bias_out <= hiz_d;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    AST_RATE: assert property (##1 softmute_rate_out == $past(cfg3_q[15:14]))
        else $error("rate output mismatch");
    AST_DEPTH: assert property (softmute_atten_db_out <= 5'd16)
        else $error("softmute depth exceeded");
    AST_EXTENDED_VOLUME_RANGE: assert property (cfg3_q[8] && $stable(cfg3_q) && $stable(volume_in)
        |=> volume_atten_db_out >= 6'd30)
        else $error("extended volume not applied");
    AST_SNR: assert property (wr_in && addr_in == 4'h6 && wdata_in[7:4] == 4'h0
        |=> ##1 !seek_snr_check_out)
        else $error("snr check not disabled");
    AST_IMP: assert property (wr_in && addr_in == 4'h6 && wdata_in[3:0] != 4'h0
        |=> ##1 seek_impulse_check_out)
        else $error("impulse check not enabled");
    AST_HIZ: assert property (pwr_sync_q[1] |=> !left_audio_out_bias_out)
        else $error("bias while powered");
    AST_RST: assert property ($fell(sys_rst_in) |-> test1_q == 16'h0100 && cfg3_q == 16'h0)
        else $error("bad reset value");
    AST_MUTE: assert property (volume_in == 4'h0 |=> volume_mute_out)
        else $error("volume zero not muted");
    AST_RW: assert property (wr_in && addr_in == 4'h8 ##1 rd_in && addr_in == 4'h8
        |=> rdata_out == $past(wdata_in, 2))
        else $error("readback mismatch");
    COV_WR: cover property (wr_in && addr_in == 4'h7);
    COV_HIZ: cover property (left_audio_out_bias_out);
    COV_MUTE: cover property (softmute_atten_db_out == 5'd10);
endmodule // tuner_config_test_registers
`default_nettype wire

// ===== testbench/tuner_config_test_registers_test.sv
// Self-checking bench for the config/test register group
`include "tuner_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tuner_config_test_registers_test;
    import tuner_cfg_pkg::*;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    addr_t addr_in = 4'h0;
    word_t wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic pwr = 1'b0;
    logic vio = 1'b1;
    logic [3:0] vol = 4'h0;
    logic mreq = 1'b0;
    word_t rdata_out;
    word_t w;
    logic [1:0] rate;
    logic [4:0] smatt;
    logic [5:0] vatt;
    logic vmute, snr_chk, imp_chk, xosc, lbias, rbias;
    logic [3:0] snr_th, imp_th;
    int num_errors = 0;
    int n_tests = 0;
    int cnt [5];
    always #5 mclk_in = ~mclk_in;
    tuner_config_test_registers dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .power_enable_in(pwr), .vio_present_in(vio),
        .volume_in(vol), .softmute_req_in(mreq), .softmute_rate_out(rate),
        .softmute_atten_db_out(smatt), .volume_atten_db_out(vatt),
        .volume_mute_out(vmute), .seek_snr_threshold_out(snr_th),
        .seek_snr_check_out(snr_chk), .seek_impulse_threshold_out(imp_th),
        .seek_impulse_check_out(imp_chk), .crystal_osc_enable_out(xosc),
        .left_audio_out_bias_out(lbias), .right_audio_out_bias_out(rbias));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input addr_t a, input word_t d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input addr_t a, input word_t exp, input string what);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk(what, rdata_out, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    // Bounded wait for the ramp; a run-out shows up as a mismatch
    task automatic ramp(input logic [4:0] exp, output int n);
        for (n = 0; n < 20000 && smatt !== exp; n++) begin
            @(posedge mclk_in);
            #1;
        end
        chk("softmute atten", smatt, exp);
        if (n >= 20000) end_of_test();
        @(posedge mclk_in);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #1 chk("reset outs", {vmute, xosc, lbias, rbias}, 4'h8);
        chk_rd(`OFS_SYS_CFG3, `RST_SYS_CFG3, "cfg3 reset");
        chk_rd(`OFS_TEST_ONE, `RST_TEST_ONE, "test1 reset");
        chk_rd(`OFS_TEST_TWO, `RST_TEST_TWO, "test2 reset");
        chk_rd(`OFS_BOOT_CFG, `RST_BOOT_CFG, "boot reset");
        chk_rd(4'h5, 16'h0000, "unmapped read");
        for (int k = 0; k < 16; k++) begin
            w = {k[1:0], k[3:2], 3'b000, k[0], 1'b0, k[2:0], 4'(15 - k)};
            @(posedge mclk_in);
            vol <= k[3:0];
            wr(`OFS_SYS_CFG3, w);
            chk_rd(`OFS_SYS_CFG3, w, "cfg3 readback");
            chk("rate", rate, k[1:0]);
            chk("snr", {snr_chk, snr_th}, {k[2:0] != 0, 1'b0, k[2:0]});
            chk("impulse", {imp_chk, imp_th}, {k != 15, 4'(15 - k)});
            chk("volume", {vmute, vatt}, {k == 0, 6'(2 * (15 - k) + (k[0] ? 30 : 0))});
        end
        // Each depth ramps up from silence and back, so every step is exercised
        for (int d = 0; d < 5; d++) begin
            wr(`OFS_SYS_CFG3, {(d == 4) ? 2'b01 : 2'b00, 2'(d), 12'h000});
            mreq <= 1'b1;
            ramp(5'(16 - 2 * (d % 4)), cnt[d]);
            mreq <= 1'b0;
            ramp(5'h00, cnt[d]);
        end
        chk("slower rate", cnt[4] > cnt[3], 1'b1);
        wr(`OFS_TEST_ONE, 16'hc100);
        settle(5);
        chk("bias down", {xosc, lbias, rbias}, 3'b111);
        @(posedge mclk_in);
        vio <= 1'b0;
        settle(5);
        chk("bias no supply", {xosc, lbias, rbias}, 3'b100);
        @(posedge mclk_in);
        vio <= 1'b1;
        pwr <= 1'b1;
        settle(5);
        chk("bias powered", {xosc, lbias, rbias}, 3'b100);
        wr(`OFS_TEST_ONE, 16'hfc04);
        chk_rd(`OFS_TEST_ONE, 16'hfc04, "test1 up");
        settle(5);
        chk("bias still off", {lbias, rbias}, 2'b00);
        @(posedge mclk_in);
        pwr <= 1'b0;
        settle(5);
        chk("bias back", {lbias, rbias}, 2'b11);
        wr(`OFS_TEST_ONE, 16'h0100);
        settle(2);
        chk("xosc off", {xosc, lbias, rbias}, 3'b000);
        chk_rd(`OFS_TEST_TWO, `RST_TEST_TWO, "test2 before");
        wr(`OFS_TEST_TWO, `RST_TEST_TWO);
        chk_rd(`OFS_BOOT_CFG, `RST_BOOT_CFG, "boot before");
        wr(`OFS_BOOT_CFG, `RST_BOOT_CFG);
        // Write then read with no idle cycle between the strobes
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= `OFS_TEST_TWO;
        wdata_in <= 16'ha5c3;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk("test2 back to back", rdata_out, 16'ha5c3);
        wr(`OFS_BOOT_CFG, 16'h5a3c);
        wr(4'ha, 16'hffff);
        chk_rd(`OFS_TEST_TWO, 16'ha5c3, "test2 readback");
        chk_rd(`OFS_BOOT_CFG, 16'h5a3c, "boot readback");
        end_of_test();
    end
endmodule // tuner_config_test_registers_test
`default_nettype wire
